// ==== rtl/nsrf_defines.svh ====
// offsets, field positions, codes and counts of the subframe report framer
`ifndef NSRF_DEFINES_SVH
`define NSRF_DEFINES_SVH
`define NSRF_REG_CTRL     8'h00
`define NSRF_REG_STAT     8'h04
`define NSRF_REG_RPTCNT   8'h08
`define NSRF_REG_DROPCNT  8'h0c
`define NSRF_CTRL_EN_BIT  0
`define NSRF_CTRL_RESET   32'h00000000
`define NSRF_GNSS_GPS     8'h00
`define NSRF_GNSS_SBAS    8'h01
`define NSRF_GNSS_GAL     8'h02
`define NSRF_GNSS_BDS     8'h03
`define NSRF_GNSS_QZSS    8'h05
`define NSRF_GNSS_GLO     8'h06
`define NSRF_WC_GPS       8'h0a
`define NSRF_WC_SBAS      8'h09
`define NSRF_WC_GAL       8'h08
`define NSRF_WC_GLO       8'h03
`define NSRF_WC_NONE      8'h00
`define NSRF_SV_UNKNOWN   8'hff
`define NSRF_MAX_WORDS    10
`define NSRF_INV_MASK     32'h3fffffc0
`define NSRF_BDS_MASK     32'h3fffffff
`endif

// ==== rtl/nsrf_pkg.sv ====
// types of the subframe report framer
package nsrf_pkg;
  // source identity, sampled with the first word of a subframe
  typedef struct packed {
    logic [7:0]  gnss_id;
    logic [7:0]  signal_id;
    logic [7:0]  sv_id;
    logic        sv_known;
    logic        frame_known;
    logic [7:0]  frame_num;
    logic [15:0] superframe_num;
  } nsrf_src_s;
  // one decoded word from the bit decoder
  typedef struct packed {
    logic [31:0] data;
    logic        parity_ok;
    logic        invert;
    logic        last;
  } nsrf_word_s;
  // one word of the outgoing report
  typedef struct packed {
    logic [31:0] data;
    logic        first;
    logic        last;
  } nsrf_rpt_s;
  typedef enum logic [1:0] {ST_COLLECT, ST_HEAD, ST_BODY, ST_EXTRA} nsrf_state_e;
endpackage

// ==== rtl/nsrf_framer.sv ====
// subframe report framer: collects decoded words and emits one report per subframe
`timescale 1ns/1ps
`include "nsrf_defines.svh"
// Operation
// - one report per complete decoded subframe when enabled
// - navigation bits passed on as received apart from inversion and BeiDou padding
// - payload in 32-bit words with word count
// - report carries constellation id for host parsing
// - report only after complete subframe, parity passed
// - apply required bit inversion before output
// - GPS legacy and BeiDou: ten words, arrival order
// - GPS L2C: ten words per subframe
// - GLONASS string packed into three words
// - GLONASS fourth word frame numbers, zero unknown
// - unidentified GLONASS satellite reported as 255
// - BeiDou top two bits are padding
// - Galileo page pair in eight words
// - Galileo alert pages keep page-type bits
// - SBAS 250-bit block in data words
// - QZSS uses the GPS word structures
// - constellation ids 0,1,2,3,5,6 and signal ids
// - word counts 10,9,8,3 by constellation
module nsrf_framer
  import nsrf_pkg::*;
#(
  parameter int MAX_WORDS = `NSRF_MAX_WORDS
)
(
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  // decoded words from the bit decoder
  input  wire logic        in_valid,
  input  wire nsrf_word_s  in_word,
  input  wire nsrf_src_s   in_src,
  output logic             in_ready,
  // report stream to the host
  output logic             out_valid,
  output nsrf_rpt_s        out_rpt
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic [7:0] word_count_of(input logic [7:0] gnss);
    case (gnss)
      `NSRF_GNSS_GPS, `NSRF_GNSS_BDS, `NSRF_GNSS_QZSS: word_count_of = `NSRF_WC_GPS;
      `NSRF_GNSS_SBAS: word_count_of = `NSRF_WC_SBAS;
      `NSRF_GNSS_GAL:  word_count_of = `NSRF_WC_GAL;
      `NSRF_GNSS_GLO:  word_count_of = `NSRF_WC_GLO;
      default:         word_count_of = `NSRF_WC_NONE;
    endcase
  endfunction

  // bits stay as received apart from inversion and beidou padding
  function automatic logic [31:0] shape_word(input logic [31:0] d, input logic inv,
                                             input logic [7:0] gnss);
    logic [31:0] w;
    w = d;
    if (inv)
      w = w ^ `NSRF_INV_MASK;
    if (gnss == `NSRF_GNSS_BDS)
      w = w & `NSRF_BDS_MASK;
    shape_word = w;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // state

  nsrf_state_e state_ff;
  nsrf_src_s   src_ff;
  logic [31:0] mem_ff [MAX_WORDS];
  logic [7:0]  cnt_ff;
  logic [7:0]  idx_ff;
  logic        par_bad_ff;
  logic        en_ff;
  logic [15:0] rpt_cnt_ff;
  logic [15:0] drop_cnt_ff;
  logic        in_ready_ff;
  logic        out_valid_ff;
  nsrf_rpt_s   out_rpt_ff;
  logic [31:0] rdata_ff;

  nsrf_src_s   cur_src;
  logic [7:0]  cur_wc;
  logic [7:0]  rpt_wc;
  logic        take;
  logic        good_end;
  logic        body_end;
  logic        is_glo;

  assign cur_src  = (cnt_ff == 8'h00) ? in_src : src_ff;
  assign cur_wc   = word_count_of(cur_src.gnss_id);
  assign rpt_wc   = word_count_of(src_ff.gnss_id);
  assign take     = (state_ff == ST_COLLECT) && in_valid && en_ff;
  assign good_end = take && in_word.last && !par_bad_ff && in_word.parity_ok
                    && (cur_wc != `NSRF_WC_NONE) && (cnt_ff + 8'h01 == cur_wc);
  assign is_glo   = (src_ff.gnss_id == `NSRF_GNSS_GLO);
  assign body_end = (idx_ff + 8'h01 == rpt_wc);

  ////////////////////////////////////////////////////////////////////////////
  // sequencing

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      state_ff <= ST_COLLECT;
      idx_ff   <= 8'h00;
    end
    else
    begin
      case (state_ff)
        ST_COLLECT:
        begin
          if (good_end)
            state_ff <= ST_HEAD;
          idx_ff <= 8'h00;
        end
        ST_HEAD:
          state_ff <= ST_BODY;
        ST_BODY:
        begin
          idx_ff <= idx_ff + 8'h01;
          if (body_end)
            state_ff <= is_glo ? ST_EXTRA : ST_COLLECT;
        end
        ST_EXTRA:
          state_ff <= ST_COLLECT;
        default:
          state_ff <= ST_COLLECT;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // collection

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      cnt_ff     <= 8'h00;
      par_bad_ff <= 1'b0;
      src_ff     <= '0;
    end
    else if (!en_ff || state_ff != ST_COLLECT)
    begin
      // disabling drops a half-collected subframe
      cnt_ff     <= 8'h00;
      par_bad_ff <= 1'b0;
    end
    else if (take)
    begin
      if (cnt_ff == 8'h00)
        src_ff <= in_src;
      if (in_word.last)
      begin
        cnt_ff     <= 8'h00;
        par_bad_ff <= 1'b0;
      end
      else
      begin
        // overlong subframes stop counting and fail the length check
        if (cnt_ff < 8'(MAX_WORDS))
          cnt_ff <= cnt_ff + 8'h01;
        par_bad_ff <= par_bad_ff | ~in_word.parity_ok;
      end
    end
  end

  always_ff @(posedge mclk)
  begin
    if (take && cnt_ff < 8'(MAX_WORDS))
      mem_ff[cnt_ff[3:0]] <= shape_word(in_word.data, in_word.invert, cur_src.gnss_id);
  end

  // decoder is held off while a report goes out
  always_ff @(posedge mclk)
  begin
    if (rst)
      in_ready_ff <= 1'b1;
    else if (good_end)
      in_ready_ff <= 1'b0;
    else if ((state_ff == ST_BODY && body_end && !is_glo) || state_ff == ST_EXTRA)
      in_ready_ff <= 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // report output

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      out_valid_ff <= 1'b0;
      out_rpt_ff   <= '0;
    end
    else
    begin
      out_valid_ff <= 1'b0;
      out_rpt_ff   <= '0;
      case (state_ff)
        ST_HEAD:
        begin
          out_valid_ff     <= 1'b1;
          out_rpt_ff.first <= 1'b1;
          out_rpt_ff.data[31:24] <= src_ff.gnss_id;
          out_rpt_ff.data[23:16] <= src_ff.signal_id;
          out_rpt_ff.data[7:0]   <= rpt_wc;
          out_rpt_ff.data[15:8]  <= (is_glo && !src_ff.sv_known) ? `NSRF_SV_UNKNOWN
                                                                   : src_ff.sv_id;
        end
        ST_BODY:
        begin
          out_valid_ff    <= 1'b1;
          out_rpt_ff.data <= mem_ff[idx_ff[3:0]];
          out_rpt_ff.last <= body_end && !is_glo;
        end
        ST_EXTRA:
        begin
          out_valid_ff    <= 1'b1;
          out_rpt_ff.last <= 1'b1;
          if (src_ff.frame_known)
            out_rpt_ff.data <= {8'h00, src_ff.superframe_num, src_ff.frame_num};
        end
        default:
          out_valid_ff <= 1'b0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge mclk)
  begin
    if (rst)
      en_ff <= 1'(`NSRF_CTRL_RESET >> `NSRF_CTRL_EN_BIT);
    else if (reg_wr && reg_addr == `NSRF_REG_CTRL)
      en_ff <= reg_wdata[`NSRF_CTRL_EN_BIT];
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      rpt_cnt_ff  <= 16'h0000;
      drop_cnt_ff <= 16'h0000;
    end
    else
    begin
      if (out_valid_ff && out_rpt_ff.last)
        rpt_cnt_ff <= rpt_cnt_ff + 16'h0001;
      // a write to the drop count register clears it; a drop in that cycle still counts
      if (take && in_word.last && !good_end)
        drop_cnt_ff <= (reg_wr && reg_addr == `NSRF_REG_DROPCNT) ? 16'h0001
                                                                 : drop_cnt_ff + 16'h0001;
      else if (reg_wr && reg_addr == `NSRF_REG_DROPCNT)
        drop_cnt_ff <= 16'h0000;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
      rdata_ff <= 32'h00000000;
    else if (reg_rd)
    begin
      case (reg_addr)
        `NSRF_REG_CTRL:    rdata_ff <= {31'h00000000, en_ff};
        `NSRF_REG_STAT:    rdata_ff <= {16'h0000, cnt_ff, 6'h00, state_ff};
        `NSRF_REG_RPTCNT:  rdata_ff <= {16'h0000, rpt_cnt_ff};
        `NSRF_REG_DROPCNT: rdata_ff <= {16'h0000, drop_cnt_ff};
        default:           rdata_ff <= 32'h00000000;
      endcase
    end
    else
      rdata_ff <= 32'h00000000;
  end

  assign reg_rdata = rdata_ff;
  assign in_ready  = in_ready_ff;
  assign out_valid = out_valid_ff;
  assign out_rpt   = out_rpt_ff;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  a_report_starts: assert property (@(posedge mclk) disable iff (rst)
    good_end |-> ##2 (out_valid && out_rpt.first))
    else $error("report did not start after a good subframe");

  a_parity_blocks: assert property (@(posedge mclk) disable iff (rst)
    (take && in_word.last && (par_bad_ff || !in_word.parity_ok))
      |=> (state_ff == ST_COLLECT) ##1 !out_valid)
    else $error("report emitted for a subframe with failed parity");

  a_header_count: assert property (@(posedge mclk) disable iff (rst)
    (out_valid && out_rpt.first) |-> (out_rpt.data[7:0] == word_count_of(out_rpt.data[31:24])))
    else $error("header word count does not match constellation");

  a_glo_unknown: assert property (@(posedge mclk) disable iff (rst)
    (out_valid && out_rpt.first && out_rpt.data[31:24] == `NSRF_GNSS_GLO && !src_ff.sv_known)
      |-> (out_rpt.data[15:8] == `NSRF_SV_UNKNOWN))
    else $error("unidentified glonass satellite not reported as unknown");

  a_bds_pad: assert property (@(posedge mclk) disable iff (rst)
    (out_valid && !out_rpt.first && src_ff.gnss_id == `NSRF_GNSS_BDS)
      |-> (out_rpt.data[31:30] == 2'b00))
    else $error("beidou padding bits not cleared");

  a_ten_words: assert property (@(posedge mclk) disable iff (rst)
    (out_valid && out_rpt.first && out_rpt.data[7:0] == `NSRF_WC_GPS)
      |=> (out_valid && !out_rpt.last) [*8] ##1 (out_valid && !out_rpt.last)
          ##1 (out_valid && out_rpt.last))
    else $error("ten-word report has wrong length");

  a_gal_eight: assert property (@(posedge mclk) disable iff (rst)
    (out_valid && out_rpt.first && out_rpt.data[31:24] == `NSRF_GNSS_GAL)
      |-> ##8 (out_valid && out_rpt.last))
    else $error("galileo report not eight words");

  a_glo_extra: assert property (@(posedge mclk) disable iff (rst)
    (out_valid && out_rpt.first && out_rpt.data[31:24] == `NSRF_GNSS_GLO)
      |-> ##4 (out_valid && out_rpt.last
               && (src_ff.frame_known || out_rpt.data == 32'h00000000)))
    else $error("glonass frame word missing or not zero when unknown");

  a_inverted: assert property (@(posedge mclk) disable iff (rst)
    (take && in_word.invert && cur_src.gnss_id == `NSRF_GNSS_GPS && cnt_ff < 8'h0a)
      |=> (mem_ff[$past(cnt_ff[3:0])] == ($past(in_word.data) ^ `NSRF_INV_MASK)))
    else $error("inverted word stored without inversion");

  a_sbas_nine: assert property (@(posedge mclk) disable iff (rst)
    (out_valid && out_rpt.first && out_rpt.data[31:24] == `NSRF_GNSS_SBAS)
      |-> ##9 (out_valid && out_rpt.last))
    else $error("sbas report not nine words");

  a_ready_drop: assert property (@(posedge mclk) disable iff (rst)
    good_end |=> !in_ready)
    else $error("decoder not held off after a good subframe");

  a_idle_zero: assert property (@(posedge mclk) disable iff (rst)
    !out_valid |-> (out_rpt == '0))
    else $error("report word not zero while idle");

endmodule

// ==== verification/nsrf_host_model.sv ====
// host-side model that collects report words and checks framing
`timescale 1ns/1ps
module nsrf_host_model
  import nsrf_pkg::*;
(
  // clock
  input wire logic      mclk,
  // report stream
  input wire logic      out_valid,
  input wire nsrf_rpt_s out_rpt
);
  logic [31:0] words [0:15];
  int          n       = 0;
  int          reports = 0;
  int          bad     = 0;
  logic [7:0]  gnss    = 8'h00;
  always @(posedge mclk)
  begin
    if (out_valid)
    begin
      if (out_rpt.first)
      begin
        n = 0;
        gnss = out_rpt.data[31:24];
      end
      words[n] = (gnss == 8'h03 && n > 0) ? (out_rpt.data & 32'h3fffffff) : out_rpt.data;
      if (n < 15)
        n++;
      if (out_rpt.last)
      begin
        reports++;
        if (n != 32'(words[0][7:0]) + ((gnss == 8'h06) ? 2 : 1))
          bad++;
      end
    end
  end
endmodule

// ==== verification/nsrf_framer_tb.sv ====
// self-checking testbench of the subframe report framer
`timescale 1ns/1ps
`include "nsrf_defines.svh"
module nsrf_framer_tb;
  import nsrf_pkg::*;
  logic        mclk;
  logic        rst;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [31:0] reg_rdata;
  logic        in_valid;
  nsrf_word_s  in_word;
  nsrf_src_s   in_src;
  logic        in_ready;
  logic        out_valid;
  nsrf_rpt_s   out_rpt;
  int          mismatches = 0;
  int          cmp_count  = 0;
  int          exp_rpts   = 0;
  bit          en         = 1'b1;
  logic [31:0] d;
  localparam logic [15:0] SIGS [15] = '{16'h0000, 16'h0003, 16'h0004, 16'h0100, 16'h0201,
    16'h0205, 16'h0300, 16'h0301, 16'h0302, 16'h0303, 16'h0500, 16'h0504, 16'h0505,
    16'h0600, 16'h0602};

  nsrf_framer dut (.mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .in_valid(in_valid),
    .in_word(in_word), .in_src(in_src), .in_ready(in_ready), .out_valid(out_valid),
    .out_rpt(out_rpt));
  nsrf_host_model host (.mclk(mclk), .out_valid(out_valid), .out_rpt(out_rpt));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  function automatic logic [7:0] wc(input logic [7:0] g);
    case (g)
      8'h01: wc = 8'h09;
      8'h02: wc = 8'h08;
      8'h06: wc = 8'h03;
      default: wc = 8'h0a;
    endcase
  endfunction
  // top bits set so padding and inversion both show
  function automatic logic [31:0] dat(input logic [7:0] g, input int i);
    dat = {8'hc5, g, 8'(8'ha0 + i), 8'h3c};
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  task automatic sf(input logic [7:0] g, s, sv, input bit known, fk, inv, input int nw, badw);
    int r0;
    bit good;
    logic [31:0] e;
    r0 = host.reports;
    good = en && (badw < 0) && (nw == 32'(wc(g)));
    for (int i = 0; i < nw; i++)
    begin
      @(posedge mclk);
      in_valid <= 1'b1;
      in_word <= '{data: dat(g, i), parity_ok: (i != badw), invert: inv, last: (i == nw - 1)};
      in_src <= '{g, s, sv, known, fk, 8'h2d, 16'h1b3c};
    end
    @(posedge mclk);
    in_valid <= 1'b0;
    #1 chk(32'(in_ready), 32'(!good));
    for (int k = 0; k < 30 && host.reports == r0; k++)
      @(posedge mclk);
    #1 chk(32'(host.reports - r0), 32'(good));
    if (good)
    begin
      exp_rpts++;
      chk(host.words[0], {g, s, (g == 8'h06 && !known) ? 8'hff : sv, wc(g)});
      chk(32'(host.n), 32'(wc(g)) + ((g == 8'h06) ? 32'h2 : 32'h1));
      chk(32'(host.bad), 32'h0);
      for (int i = 0; i < nw; i++)
      begin
        e = dat(g, i) ^ (inv ? `NSRF_INV_MASK : 32'h0);
        chk(host.words[i + 1], (g == 8'h03) ? (e & `NSRF_BDS_MASK) : e);
      end
      if (g == 8'h06)
        chk(host.words[4], fk ? {8'h00, 16'h1b3c, 8'h2d} : 32'h0);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    rd(`NSRF_REG_CTRL, d);
    chk(d, `NSRF_CTRL_RESET);
    @(posedge mclk);
    #1 chk(reg_rdata, 32'h0);
    rd(8'h10, d);
    chk(d, 32'h0);
    rd(`NSRF_REG_STAT, d);
    chk(d, 32'h0);
    wr(`NSRF_REG_CTRL, 32'h1);
    rd(`NSRF_REG_CTRL, d);
    chk(d, 32'h1);
  endtask
  task automatic t_disabled;
    wr(`NSRF_REG_CTRL, 32'h0);
    en = 1'b0;
    sf(8'h00, 8'h00, 8'h04, 1'b1, 1'b0, 1'b0, 10, -1);
    wr(`NSRF_REG_CTRL, 32'h1);
    en = 1'b1;
  endtask
  // every tabulated signal, odd entries sent with the invert flag set
  task automatic t_signals;
    for (int k = 0; k < 15; k++)
      sf(SIGS[k][15:8], SIGS[k][7:0], 8'(k + 1), 1'b1, 1'b0, k[0], 32'(wc(SIGS[k][15:8])), -1);
    rd(`NSRF_REG_RPTCNT, d);
    chk(d, 32'(exp_rpts));
  endtask
  task automatic t_glonass;
    sf(8'h06, 8'h00, 8'h07, 1'b0, 1'b0, 1'b0, 3, -1);
    sf(8'h06, 8'h02, 8'h09, 1'b1, 1'b1, 1'b0, 3, -1);
  endtask
  task automatic t_drop;
    sf(8'h00, 8'h00, 8'h01, 1'b1, 1'b0, 1'b0, 10, 9);
    sf(8'h02, 8'h01, 8'h01, 1'b1, 1'b0, 1'b0, 7, -1);
    rd(`NSRF_REG_DROPCNT, d);
    chk(d, 32'h2);
    wr(`NSRF_REG_DROPCNT, 32'h0);
    rd(`NSRF_REG_DROPCNT, d);
    chk(d, 32'h0);
    sf(8'h01, 8'h00, 8'h03, 1'b1, 1'b0, 1'b1, 9, -1);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  initial
  begin
    rst = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    in_valid = 1'b0;
    in_word = '0;
    in_src = '0;
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    t_regs;
    t_disabled;
    t_signals;
    t_glonass;
    t_drop;
    give_verdict;
  end
  // a run of about 500 cycles, cut off well beyond it
  initial
  begin
    #300000;
    mismatches++;
    give_verdict;
  end
endmodule
